// *** verilog/t8w_timer.sv ***
// 8-bit timer with clear-on-match, fast PWM and phase-correct PWM waveform modes
// assumes synchronous inputs, one strobe per cycle, read data one cycle after rd_stb
`timescale 1ns/1ps

// Functional notes
// R1 - mode 2 clears the count after it matches compare A
// R2 - clear-on-match sets compare A flag at top, request when enabled
// R3 - clear-on-match compare writes are direct; missed match wraps through 0xFF
// R4 - compare output mode 1 toggles output on each match in clear-on-match
// R5 - pin is driven only when its direction bit selects output
// R6 - clear-on-match sets overflow when count rolls from max to zero
// R7 - modes 3 and 7 are single-slope fast PWM
// R8 - fast PWM top is 0xFF in mode 3, compare A in mode 7
// R9 - fast PWM counts to top then goes to zero next tick
// R10 - fast PWM non-inverting clears on match, sets at bottom; inverting opposite
// R11 - fast PWM sets overflow when count reaches top
// R12 - fast PWM compare at bottom gives spike, at max steady level
// R13 - fast PWM mode 1 toggles on match with buffered compare
// R14 - timer clock is clk_sys divided by 1,8,32,64,128,256 or 1024
// R15 - fast PWM with fixed top has a 256-tick period
// R16 - modes 1 and 5 are dual-slope phase-correct PWM
// R17 - phase-correct count stays at top one tick, then reverses
// R18 - phase-correct non-inverting clears on up match, sets on down match
// R19 - phase-correct sets overflow when count reaches bottom
// R20 - phase-correct compare at bottom gives steady low, at max steady high; inverting opposite
// R21 - compare leaving max forces the up-match level at bottom
// R22 - a missed up-slope match still applies its output change
// R23 - PWM compare writes are buffered, loaded at top; others direct
// R24 - compare output mode 0 leaves the pin to its port function
// R25 - phase-correct top is 0xFF in mode 1, compare A in mode 5
module t8w_timer
  import t8w_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire t8w_bus_req_t bus_req,
  output logic [7:0] rdata,
  output logic pin_out,
  output logic pin_oe,
  output logic irq_ovf,
  output logic irq_cmp
);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [2:0] waveform_mode_sel;
  logic [1:0] compare_output_mode_a;
  logic [2:0] clk_sel;
  logic [7:0] timer_count;
  logic [7:0] compare_a_value;
  logic [7:0] compare_a_buf;
  logic overflow_flag;
  logic compare_a_flag;
  logic ovf_en;
  logic cmp_en;
  logic port_bit;
  logic dir_bit;
  logic wave_out_a;
  logic count_up;
  logic seen_up;
  logic was_max;
  logic tick;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire logic wr_ctrl = bus_req.wr_stb && (bus_req.addr == REG_CTRL);
  wire logic wr_clksel = bus_req.wr_stb && (bus_req.addr == REG_CLKSEL);
  wire logic wr_count = bus_req.wr_stb && (bus_req.addr == REG_COUNT);
  wire logic wr_cmpa = bus_req.wr_stb && (bus_req.addr == REG_CMPA);
  wire logic wr_flags = bus_req.wr_stb && (bus_req.addr == REG_FLAGS);
  wire logic wr_irqen = bus_req.wr_stb && (bus_req.addr == REG_IRQEN);
  wire logic wr_pin = bus_req.wr_stb && (bus_req.addr == REG_PIN);
  wire logic clr_ovf = wr_flags && bus_req.wdata[FLAG_OVF_BIT];
  wire logic clr_cmp = wr_flags && bus_req.wdata[FLAG_CMP_BIT];

  // ****************************************************************
  // mode decode
  // ****************************************************************
  // R16 - dual-slope modes
  wire logic is_pc = (waveform_mode_sel == WGM_PC_FF) || (waveform_mode_sel == WGM_PC_CMP);
  // R7 - single-slope modes
  wire logic is_fast = (waveform_mode_sel == WGM_FAST_FF) || (waveform_mode_sel == WGM_FAST_CMP);
  wire logic is_ctc = (waveform_mode_sel == WGM_CTC);
  wire logic is_pwm = is_pc || is_fast;
  // R8 - top select
  // R25 - top select
  wire logic [7:0] top_val = (is_pwm && waveform_mode_sel[WGM_TOP_BIT]) ? compare_a_value : CNT_MAX;
  wire logic match = (timer_count == compare_a_value);
  wire logic at_top = (timer_count == top_val);
  wire logic at_bottom = (timer_count == CNT_BOTTOM);
  wire logic pc_turn_top = is_pc && count_up && (timer_count >= top_val);
  wire logic pc_turn_bot = is_pc && !count_up && at_bottom;
  // level left by an up-slope match; the down match leaves its inverse
  wire logic up_level = (compare_output_mode_a == COM_INV);
  wire logic com_pwm = compare_output_mode_a[1];
  // match action outside the dual-slope modes: toggle, clear or set
  wire logic match_wave = (compare_output_mode_a == COM_TOGGLE) ? !wave_out_a :
    ((compare_output_mode_a == COM_NONE) ? wave_out_a : compare_output_mode_a[0]);

  // ****************************************************************
  // next-state logic, applied on the timer tick
  // ****************************************************************
  logic [7:0] next_count;
  logic next_up;
  logic next_wave;
  logic next_seen;
  logic next_was_max;
  logic ovf_set;
  logic cmp_set;
  logic load_buf;

  always_comb begin
    next_count = timer_count;
    next_up = count_up;
    next_wave = wave_out_a;
    next_seen = seen_up;
    next_was_max = was_max;
    ovf_set = 1'b0;
    cmp_set = 1'b0;
    load_buf = 1'b0;
    if (tick) begin
      // R2 - compare flag on match
      cmp_set = match;
      if (is_pc) begin
        if (pc_turn_top) begin
          // R17 - one tick at top, then down
          next_up = 1'b0;
          next_count = (top_val == CNT_BOTTOM) ? CNT_BOTTOM : 8'(top_val - 8'h01);
          // R23 - buffered compare loaded at top
          load_buf = 1'b1;
          next_was_max = (compare_a_value == top_val);
        end else if (pc_turn_bot) begin
          next_up = 1'b1;
          next_count = (top_val == CNT_BOTTOM) ? CNT_BOTTOM : 8'h01;
          next_seen = 1'b0;
          // R19 - overflow at bottom
          ovf_set = 1'b1;
        end else if (count_up) begin
          next_count = 8'(timer_count + 8'h01);
        end else begin
          next_count = 8'(timer_count - 8'h01);
        end
        if (com_pwm) begin
          // R18 - up match clears, down match sets (non-inverting)
          // R20 - top match acts as down, bottom match as up
          if (match) begin
            if (at_top) begin
              next_wave = !up_level;
            end else if (at_bottom || count_up) begin
              next_wave = up_level;
            end else begin
              next_wave = !up_level;
            end
          end
          if (match && count_up) begin
            next_seen = 1'b1;
          end
          // R22 - missed up-slope match
          if (pc_turn_top && !seen_up && !match && (compare_a_value < top_val)) begin
            next_wave = up_level;
          end
          // R21 - compare left max: up-match level at bottom
          if (pc_turn_bot && was_max && (compare_a_value != top_val)) begin
            next_wave = up_level;
          end
        end
      end else if (is_fast) begin
        // R9 - top then zero
        // R15 - fixed-top period
        if (at_top) begin
          next_count = CNT_BOTTOM;
          // R11 - overflow at top
          ovf_set = 1'b1;
          load_buf = 1'b1;
        end else begin
          next_count = 8'(timer_count + 8'h01);
        end
        // R13 - toggle on match
        // R10 - match action, bottom action wins after
        // R12 - bottom value gives a one-tick spike
        if (match) begin
          next_wave = match_wave;
        end
        if (at_top && com_pwm) begin
          next_wave = !up_level;
        end
      end else begin
        // R1 - clear after match
        // R3 - lower compare runs on through 0xFF
        if (is_ctc && match) begin
          next_count = CNT_BOTTOM;
        end else begin
          next_count = 8'(timer_count + 8'h01);
          // R6 - overflow on max to zero
          ovf_set = (timer_count == CNT_MAX);
        end
        // R4 - toggle on match
        if (match) begin
          next_wave = match_wave;
        end
      end
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  logic [7:0] read_mux;
  always_comb begin
    case (bus_req.addr)
      REG_CTRL: read_mux = {2'h0, compare_output_mode_a, 1'b0, waveform_mode_sel};
      REG_CLKSEL: read_mux = {5'h00, clk_sel};
      REG_COUNT: read_mux = timer_count;
      REG_CMPA: read_mux = compare_a_buf;
      REG_FLAGS: read_mux = {6'h00, compare_a_flag, overflow_flag};
      REG_IRQEN: read_mux = {6'h00, cmp_en, ovf_en};
      REG_PIN: read_mux = {5'h00, wave_out_a, dir_bit, port_bit};
      default: read_mux = RST_BYTE;
    endcase
  end

  // R24 - mode 0 keeps port function
  wire logic next_pin_out = (compare_output_mode_a != COM_NONE) ? wave_out_a : port_bit;

  t8w_prescaler #(
    .DIV_W(PRE_W)
  ) u_pre (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .sel(clk_sel),
    .tick(tick)
  );

  // ****************************************************************
  // control registers
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      waveform_mode_sel <= WGM_NORMAL;
      compare_output_mode_a <= COM_NONE;
      clk_sel <= PRE_STOP;
      ovf_en <= 1'b0;
      cmp_en <= 1'b0;
      port_bit <= 1'b0;
      dir_bit <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        waveform_mode_sel <= bus_req.wdata[CTRL_WGM_LSB +: 3];
        compare_output_mode_a <= bus_req.wdata[CTRL_COM_LSB +: 2];
      end
      if (wr_clksel) begin
        clk_sel <= bus_req.wdata[2:0];
      end
      if (wr_irqen) begin
        ovf_en <= bus_req.wdata[FLAG_OVF_BIT];
        cmp_en <= bus_req.wdata[FLAG_CMP_BIT];
      end
      if (wr_pin) begin
        port_bit <= bus_req.wdata[PIN_PORT_BIT];
        dir_bit <= bus_req.wdata[PIN_DIR_BIT];
      end
    end
  end

  // ****************************************************************
  // counter, compare and waveform
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timer_count <= CNT_BOTTOM;
      count_up <= 1'b1;
      wave_out_a <= 1'b0;
      seen_up <= 1'b0;
      was_max <= 1'b0;
    end else if (ce) begin
      // a software count write wins over the tick
      timer_count <= wr_count ? bus_req.wdata : next_count;
      count_up <= next_up;
      wave_out_a <= next_wave;
      seen_up <= next_seen;
      was_max <= next_was_max;
    end
  end

  // R23 - PWM writes buffered, others direct
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      compare_a_value <= RST_BYTE;
      compare_a_buf <= RST_BYTE;
    end else if (ce) begin
      if (wr_cmpa) begin
        compare_a_buf <= bus_req.wdata;
      end
      if (wr_cmpa && !is_pwm) begin
        compare_a_value <= bus_req.wdata;
      end else if (load_buf) begin
        compare_a_value <= compare_a_buf;
      end
    end
  end

  // flags: a hardware set beats a same-cycle software clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      overflow_flag <= 1'b0;
      compare_a_flag <= 1'b0;
    end else if (ce) begin
      overflow_flag <= (overflow_flag && !clr_ovf) || ovf_set;
      compare_a_flag <= (compare_a_flag && !clr_cmp) || cmp_set;
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata <= RST_BYTE;
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      irq_ovf <= 1'b0;
      irq_cmp <= 1'b0;
    end else if (ce) begin
      rdata <= bus_req.rd_stb ? read_mux : RST_BYTE;
      // R5 - direction gates the pin
      pin_oe <= dir_bit;
      pin_out <= next_pin_out;
      irq_ovf <= overflow_flag && ovf_en;
      irq_cmp <= compare_a_flag && cmp_en;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_CTC_CLEAR: assert property (@(posedge clk_sys) disable iff (rst) // R1
    (ce && tick && is_ctc && match && !wr_count) |=> (timer_count == CNT_BOTTOM))
    else $error("count not cleared after match");
  AST_CMP_FLAG: assert property (@(posedge clk_sys) disable iff (rst) // R2
    (ce && tick && match) |=> compare_a_flag)
    else $error("compare flag not set on match");
  AST_CTC_TOGGLE: assert property (@(posedge clk_sys) disable iff (rst) // R4
    (ce && tick && is_ctc && match && compare_output_mode_a == COM_TOGGLE) |=> (wave_out_a != $past(wave_out_a)))
    else $error("output did not toggle on match");
  AST_PIN_DIR: assert property (@(posedge clk_sys) disable iff (rst) // R5
    (ce && !dir_bit) |=> !pin_oe)
    else $error("pin driven while direction is input");
  AST_CTC_OVF: assert property (@(posedge clk_sys) disable iff (rst) // R6
    (ce && tick && is_ctc && !match && timer_count == CNT_MAX && !wr_count) |=> (overflow_flag && at_bottom))
    else $error("overflow missing on roll to zero");
  AST_FAST_WRAP: assert property (@(posedge clk_sys) disable iff (rst) // R9
    (ce && tick && is_fast && at_top && !wr_count) |=> (at_bottom && overflow_flag))
    else $error("fast mode did not wrap at top");
  AST_PC_TOP: assert property (@(posedge clk_sys) disable iff (rst) // R17
    (ce && tick && pc_turn_top && at_top && top_val != CNT_BOTTOM && !wr_count)
      |=> (!count_up && timer_count == 8'($past(timer_count) - 8'h01)))
    else $error("dual slope did not reverse after one tick at top");
  AST_PC_OVF: assert property (@(posedge clk_sys) disable iff (rst) // R19
    (ce && tick && pc_turn_bot) |=> (overflow_flag && count_up))
    else $error("overflow missing at bottom");
  AST_READ_COUNT: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && bus_req.rd_stb && bus_req.addr == REG_COUNT) |=> (rdata == $past(timer_count)))
    else $error("count read data wrong");

endmodule

// *** verilog/t8w_pkg.sv ***
// package for the 8-bit waveform timer: register map, fields, modes, prescale codes
// assumes a single clk_sys domain with a plain strobe register port
package t8w_pkg;

  // ****************************************************************
  // register indices on the plain port
  // ****************************************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CLKSEL = 4'h1;
  localparam logic [3:0] REG_COUNT = 4'h2;
  localparam logic [3:0] REG_CMPA = 4'h3;
  localparam logic [3:0] REG_FLAGS = 4'h4;
  localparam logic [3:0] REG_IRQEN = 4'h5;
  localparam logic [3:0] REG_PIN = 4'h6;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int CTRL_WGM_LSB = 0;
  localparam int CTRL_COM_LSB = 4;
  localparam int WGM_TOP_BIT = 2;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMP_BIT = 1;
  localparam int PIN_PORT_BIT = 0;
  localparam int PIN_DIR_BIT = 1;
  localparam int PIN_WAVE_BIT = 2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'h FF;

  // ****************************************************************
  // waveform modes and compare output modes
  // ****************************************************************
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_PC_FF = 3'h1;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam logic [2:0] WGM_FAST_FF = 3'h3;
  localparam logic [2:0] WGM_PC_CMP = 3'h5;
  localparam logic [2:0] WGM_FAST_CMP = 3'h7;
  localparam logic [1:0] COM_NONE = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_NONINV = 2'h2;
  localparam logic [1:0] COM_INV = 2'h3;

  // ****************************************************************
  // prescale selections: divider masks for 1,8,32,64,128,256,1024
  // ****************************************************************
  localparam int PRE_W = 10;
  localparam logic [2:0] PRE_STOP = 3'h0;
  localparam logic [PRE_W-1:0] PRE_MASK_1 = 10'h000;
  localparam logic [PRE_W-1:0] PRE_MASK_8 = 10'h007;
  localparam logic [PRE_W-1:0] PRE_MASK_32 = 10'h01F;
  localparam logic [PRE_W-1:0] PRE_MASK_64 = 10'h03F;
  localparam logic [PRE_W-1:0] PRE_MASK_128 = 10'h07F;
  localparam logic [PRE_W-1:0] PRE_MASK_256 = 10'h0FF;
  localparam logic [PRE_W-1:0] PRE_MASK_1024 = 10'h3FF;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr_stb;
    logic rd_stb;
  } t8w_bus_req_t;

endpackage

// *** verilog/t8w_prescaler.sv ***
// timer clock enable generator: divides clk_sys by the selected factor
// assumes ce gates every edge and sel is held steady by software
`timescale 1ns/1ps
module t8w_prescaler
  import t8w_pkg::*;
#(
  parameter int DIV_W = PRE_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [2:0] sel,
  output logic tick
);

  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] sel_mask;

  // ****************************************************************
  // factor decode
  // ****************************************************************
  always_comb begin
    case (sel)
      3'h1: sel_mask = DIV_W'(PRE_MASK_1);
      3'h2: sel_mask = DIV_W'(PRE_MASK_8);
      3'h3: sel_mask = DIV_W'(PRE_MASK_32);
      3'h4: sel_mask = DIV_W'(PRE_MASK_64);
      3'h5: sel_mask = DIV_W'(PRE_MASK_128);
      3'h6: sel_mask = DIV_W'(PRE_MASK_256);
      3'h7: sel_mask = DIV_W'(PRE_MASK_1024);
      default: sel_mask = DIV_W'(PRE_MASK_1);
    endcase
  end

  wire logic running = (sel != PRE_STOP);
  wire logic hit = running && ((div_cnt & sel_mask) == sel_mask);

  // R14 - divided timer clock
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      div_cnt <= running ? DIV_W'(div_cnt + 1'b1) : '0;
      tick <= hit;
    end
  end

endmodule

// *** tb/tb.sv ***
// testbench for the 8-bit waveform timer: table of mode runs checked against a tick model
// assumes t8w_timer alone, ce held high, register port with read data one cycle late
`timescale 1ns/1ps
module tb;
  import t8w_pkg::*;
  typedef struct {
    string nm;
    logic [7:0] lo;
    logic [7:0] hi;
  } t8w_note_t;
  localparam int DV [6] = '{8, 32, 64, 128, 256, 1024};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  t8w_bus_req_t bus_req = '0;
  logic [7:0] rdata;
  logic pin_out;
  logic pin_oe;
  logic irq_ovf;
  logic irq_cmp;
  logic rd_pend = 1'b0;
  int err_total = 0;
  int n_compared = 0;
  t8w_note_t q[$];
  logic [2:0] m;
  logic [1:0] com;
  logic [7:0] cnt, act, cbuf, en;
  logic up, w, ovf, cf, wm;
  logic [36:0] tab [13];

  t8w_timer i_t8w_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .bus_req(bus_req),
    .rdata(rdata),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .irq_ovf(irq_ovf),
    .irq_cmp(irq_cmp)
  );

  always #20 clk_sys = ~clk_sys;

  // ****
  // tick model of counter, flags and wave output
  // ****
  task automatic sim(input int n);
    logic [7:0] top;
    logic mt;
    for (int i = 0; i < n; i++) begin
      top = (m == WGM_FAST_CMP || m == WGM_PC_CMP) ? act : CNT_MAX;
      mt = (cnt == act);
      cf |= mt;
      if (m == WGM_PC_FF || m == WGM_PC_CMP) begin
        if (mt && com[1]) w = ((cnt == top) ? 1'b0 : (cnt == CNT_BOTTOM) ? 1'b1 : up) ? com[0] : ~com[0];
        if (up && cnt >= top) begin
          // missed up match still lands its level at the turn
          if (act < top && com[1]) w = com[0];
          cnt = top - 8'h01;
          up = 1'b0;
          wm = (act == top);
          act = cbuf;
        end else if (!up && cnt == CNT_BOTTOM) begin
          // compare that left max lands the up-match level at bottom
          if (wm && act != top && com[1]) w = com[0];
          cnt = 8'h01;
          up = 1'b1;
          ovf = 1'b1;
        end else begin
          cnt = up ? cnt + 8'h01 : cnt - 8'h01;
        end
      end else begin
        if (mt) w = (com == COM_TOGGLE) ? ~w : (com == COM_NONE) ? w : com[0];
        if ((m == WGM_FAST_FF || m == WGM_FAST_CMP) && cnt == top) begin
          cnt = CNT_BOTTOM;
          ovf = 1'b1;
          act = cbuf;
          if (com[1]) w = ~com[0];
        end else if (m == WGM_CTC && mt) begin
          cnt = CNT_BOTTOM;
        end else begin
          ovf |= (cnt == CNT_MAX);
          cnt++;
        end
      end
    end
  endtask

  // ****
  // bus tasks, comparison and monitor
  // ****
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // each task assigns the whole request once, so back-to-back calls never double-drive
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr_stb: 1'b1, rd_stb: 1'b0};
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] lo, input logic [7:0] hi, input string nm);
    bus_req <= '{addr: a, wdata: 8'h00, wr_stb: 1'b0, rd_stb: 1'b1};
    q.push_back('{nm, lo, hi});
    @(posedge clk_sys);
  endtask

  task automatic idle(input int k);
    bus_req <= '0;
    repeat (k) @(posedge clk_sys);
  endtask

  always @(posedge clk_sys) begin
    t8w_note_t e;
    if (rd_pend) begin
      e = q.pop_front();
      if (e.lo == e.hi) begin
        chk(e.nm, rdata, e.hi);
      end else begin
        chk(e.nm, {7'h00, rdata >= e.lo && rdata <= e.hi}, 8'h01);
      end
    end
    rd_pend <= bus_req.rd_stb;
  end

  task automatic setup(input logic [2:0] md, input logic [1:0] cm, input logic [7:0] c, input logic [7:0] st);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    idle(1);
    {cnt, act, cbuf, up, w, ovf, cf, wm} = {st, c, c, 5'h10};
    wr(REG_CMPA, c);
    wr(REG_COUNT, st);
    wr(REG_PIN, 8'h02);
    wr(REG_IRQEN, en);
    wr(REG_CTRL, {2'h0, cm, 1'b0, md});
    m = md;
    com = cm;
  endtask

  // stop write lands n edges after start write, so n ticks at divide by one
  task automatic run(input logic [7:0] sel, input int n);
    wr(REG_CLKSEL, sel);
    idle(n - 1);
    wr(REG_CLKSEL, 8'h00);
    idle(3);
  endtask

  task automatic chk_all();
    rd(REG_COUNT, cnt, cnt, "count");
    rd(REG_FLAGS, {6'h00, cf, ovf}, {6'h00, cf, ovf}, "flags");
    rd(REG_PIN, {5'h00, w, 2'h2}, {5'h00, w, 2'h2}, "pin reg");
    idle(2);
    chk("pin out", {7'h00, pin_out}, {7'h00, (com != COM_NONE) & w});
    chk("pin oe", {7'h00, pin_oe}, 8'h01);
    chk("irq ovf", {7'h00, irq_ovf}, {7'h00, ovf & en[0]});
    chk("irq cmp", {7'h00, irq_cmp}, {7'h00, cf & en[1]});
    wr(REG_FLAGS, 8'h03);
    // software clear of both flags, mirrored so later runs start clean
    {ovf, cf} = 2'b00;
    rd(REG_FLAGS, 8'h00, 8'h00, "flags cleared");
    idle(2);
    chk("irq low", {6'h00, irq_ovf, irq_cmp}, 8'h00);
  endtask

  initial begin
    repeat (50000) @(posedge clk_sys);
    err_total++;
    $display("unexpected run length: expected end, seen timeout");
    test_done();
  end

  initial begin
    logic [36:0] t;
    void'($urandom(32'hab76));
    tab = '{
      {3'h2, 2'h1, 8'h09, 8'h00, 16'h0019},
      {3'h2, 2'h1, 8'h05, 8'h14, 16'h00FA},
      {3'h2, 2'h1, 8'h00, 8'h00, 16'h0007},
      {3'h3, 2'h2, 8'h40, 8'h00, 16'h012C},
      {3'h7, 2'h3, 8'h20, 8'h00, 16'h0032},
      {3'h3, 2'h1, 8'h10, 8'h00, 16'h00C8},
      {3'h3, 2'h2, 8'hFF, 8'h00, 16'h0258},
      {3'h3, 2'h2, 8'h00, 8'h00, 16'h012C},
      {3'h1, 2'h2, 8'h30, 8'h00, 16'h0258},
      {3'h5, 2'h3, 8'h28, 8'h00, 16'h0064},
      {3'h1, 2'h3, 8'h30, 8'h80, 16'h00C8},
      {3'h1, 2'h2, 8'h00, 8'h00, 16'h0208},
      {3'h1, 2'h3, 8'hFF, 8'h00, 16'h0208}
    };
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    idle(1);
    wr(4'hF, 8'hFF);
    rd(REG_CTRL, 8'h00, 8'h00, "ctrl reset");
    rd(4'hF, 8'h00, 8'h00, "unmapped");
    idle(2);
    for (int i = 0; i < 14; i++) begin
      t = (i < 13) ? tab[i] : {3'h2, 2'h1, 8'($urandom_range(60, 1)), 8'h00, 16'($urandom_range(300, 20))};
      en = i[0] ? 8'h03 : 8'h00;
      setup(t[36:34], t[33:32], t[31:24], t[23:16]);
      run(8'h01, int'(t[15:0]));
      sim(int'(t[15:0]));
      chk_all();
      $display("mode test %0d done", i);
    end
    en = 8'h03;
    setup(WGM_FAST_FF, COM_INV, 8'h40, 8'h00);
    run(8'h01, 44);
    sim(44);
    wr(REG_CMPA, 8'h60);
    cbuf = 8'h60;
    rd(REG_CMPA, 8'h60, 8'h60, "cmpa buffer");
    idle(1);
    run(8'h01, 30);
    sim(30);
    chk_all();
    run(8'h01, 200);
    sim(200);
    chk_all();
    $display("buffer test done");
    // compare leaves max on the down slope; stop just after the next-but-one bottom
    setup(WGM_PC_FF, COM_NONINV, 8'hFF, 8'h00);
    run(8'h01, 300);
    sim(300);
    wr(REG_CMPA, 8'h40);
    cbuf = 8'h40;
    run(8'h01, 740);
    sim(740);
    chk_all();
    $display("compare leaving max test done");
    for (int s = 2; s < 8; s++) begin
      setup(WGM_NORMAL, COM_NONE, 8'h00, 8'h00);
      run(8'(s), 4 * DV[s - 2]);
      rd(REG_COUNT, 8'h03, 8'h04, "prescaled count");
      idle(1);
    end
    $display("prescaler test done");
    wr(REG_PIN, 8'h01);
    idle(2);
    chk("pin out", {7'h00, pin_out}, 8'h01);
    chk("pin oe", {7'h00, pin_oe}, 8'h00);
    $display("pin test done");
    test_done();
  end
endmodule
